// *** rtl/tcb_pkg.sv ***
// package of offsets, reset values and carrier types for the timing card config bank
package tcb_pkg;

	// ==========================================================
	// register indices (byte address is four times the index)
	localparam logic [7:0]  IDX_SEC_LOOP_CTRL   = 8'h35;
	localparam logic [7:0]  IDX_COMPOSITE_IN    = 8'h36;
	localparam logic [7:0]  IDX_HOST_IF_STATUS  = 8'h37;
	localparam logic [7:0]  IDX_SYNTH_FAMILY    = 8'h38;
	localparam logic [7:0]  IDX_SYNTH_MULTIPLE  = 8'h39;
	localparam logic [7:0]  IDX_OUTPUT_FORMAT   = 8'h3A;
	localparam logic [7:0]  IDX_LOOP_FILTER     = 8'h3B;

	// ==========================================================
	// reset values; the fixed bits also serve as reserved read-back values
	localparam logic [7:0]  RST_SEC_LOOP_CTRL   = 8'h40;
	localparam logic [7:0]  RST_COMPOSITE_IN    = 8'h02;
	localparam logic [7:0]  RST_SYNTH_FAMILY    = 8'h1F;
	localparam logic [7:0]  RST_SYNTH_MULTIPLE  = 8'h08;
	localparam logic [7:0]  RST_OUTPUT_FORMAT   = 8'hC6;
	localparam logic [7:0]  RST_LOOP_FILTER     = 8'hFB;

	// writable bit masks of each writable register
	localparam logic [7:0]  WM_SEC_LOOP_CTRL    = 8'h1F;
	localparam logic [7:0]  WM_COMPOSITE_IN     = 8'hFF;
	localparam logic [7:0]  WM_SYNTH_FAMILY     = 8'hE0;
	localparam logic [7:0]  WM_SYNTH_MULTIPLE   = 8'hF0;
	localparam logic [7:0]  WM_OUTPUT_FORMAT    = 8'h3F;
	localparam logic [7:0]  WM_LOOP_FILTER      = 8'h8C;

	// ==========================================================
	// field positions
	localparam int          B_OUT89_SRC         = 4;
	localparam int          B_EDGE_SEL          = 7;
	localparam int          B_ERR_COUNT_EN      = 6;
	localparam int          B_VIOL_INVAL        = 5;
	localparam int          B_LOS_INVAL         = 4;
	localparam int          B_IN2_FORMAT        = 3;
	localparam int          B_IN1_FORMAT        = 2;
	localparam int          B_SYNTH2_ALT        = 7;
	localparam int          B_SYNTH2_FAMILY     = 6;
	localparam int          B_SYNTH1_FAMILY     = 5;
	localparam int          B_SYNTH2_MULT       = 6;
	localparam int          B_SYNTH1_MULT       = 4;
	localparam int          B_OUT8_400HZ        = 5;
	localparam int          B_OUT8_8K_DIS       = 4;
	localparam int          B_OUT7_FMT          = 2;
	localparam int          B_OUT6_FMT          = 0;
	localparam int          B_AUTO_BW           = 7;
	localparam int          B_INT_LIMIT         = 3;
	localparam int          B_DET_SEL           = 2;

	// ==========================================================
	// synthesizer base rates and the synthesizer 2 alternate rate, in kHz
	localparam logic [14:0] SYNTH_BASE_1544     = 15'd1544;
	localparam logic [14:0] SYNTH_BASE_2048     = 15'd2048;
	localparam logic [14:0] SYNTH_ALT_KHZ       = 15'd6312;

	// ==========================================================
	// timing
	localparam int          CLK_HZ              = 25_000_000;
	localparam int          ERR_INTERVAL_MS     = 128;
	localparam int          ERR_INTERVAL_CYCLES = (CLK_HZ / 1000) * ERR_INTERVAL_MS;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic bpv_lead;      // leading edge of the violation pulse
		logic next_lead;     // leading edge of the pulse after the violation
		logic period_done;   // end of one 8-bit period
		logic period_broken; // pattern broken in that period
		logic bit_strobe;    // one received bit
		logic bit_zero;      // that bit was a zero
		logic cmos_clk;      // single-ended clock on the ordinary pin
	} tcb_comp_in_type;

	typedef struct packed {
		logic        ref_clk;      // reference clock passed to the loop
		logic        invalid;      // automatic invalidation
		logic        bucket_inc;   // one-cycle leaky bucket increment
	} tcb_comp_out_type;

	typedef struct packed {
		logic [2:0]  size;
		logic        write;
		logic [7:0]  index;
	} tcb_ahb_req_type;

endpackage

// *** rtl/tcb_config_bank.sv ***
// configuration register bank of the timing card with its decoded controls
// ==========================================================
module tcb_config_bank
	import tcb_pkg::*;
#(
	parameter int ERR_INTERVAL = ERR_INTERVAL_CYCLES
) (
	input  wire logic                  clock_i,
	input  wire logic                  reset_n_i,
	// AHB-Lite slave
	input  wire logic                  hsel_i,
	input  wire logic [31:0]           haddr_i,
	input  wire logic [1:0]            htrans_i,
	input  wire logic                  hwrite_i,
	input  wire logic [2:0]            hsize_i,
	input  wire logic [31:0]           hwdata_i,
	input  wire logic                  hready_i,
	output logic      [31:0]           hrdata_o,
	output logic                       hreadyout_o,
	output logic                       hresp_o,
	// straps
	input  wire logic [2:0]            host_port_strap_i,
	input  wire logic                  rate_family_strap_i,
	input  wire logic                  primary_secondary_strap_i,
	output logic      [2:0]            host_port_control_o,
	// secondary loop reference selection
	input  wire logic [3:0]            secondary_auto_ref_i,
	input  wire logic [14:1]           input_invalid_i,
	output logic      [3:0]            secondary_loop_ref_o,
	output logic                       secondary_forced_o,
	output logic                       secondary_switch_hold_o,
	output logic                       out8_9_from_primary_o,
	// composite inputs 1 and 2
	input  tcb_comp_in_type [1:0]      comp_in_i,
	output tcb_comp_out_type [1:0]     comp_out_o,
	// synthesizers
	output logic      [14:0]           synth1_khz_o,
	output logic      [14:0]           synth2_khz_o,
	// output formats
	output logic                       out8_400hz_en_o,
	output logic                       out8_8khz_en_o,
	output logic                       out6_en_o,
	output logic                       out7_en_o,
	// primary loop
	input  wire logic                  primary_locked_i,
	input  wire logic                  freq_at_limit_i,
	input  wire logic                  test_override_i,
	output logic                       use_acq_bandwidth_o,
	output logic                       integral_freeze_o,
	output logic                       phase_freq_detector_o
);

	// ==========================================================
	// helpers
	function automatic logic [14:0] synth_khz(input logic family, input logic [1:0] mult);
		logic [14:0] base;
		base = family ? SYNTH_BASE_1544 : SYNTH_BASE_2048;
		return 15'(base << mult);
	endfunction

	function automatic logic [7:0] rd_mix(input logic [7:0] stored, input logic [7:0] fixed,
			input logic [7:0] mask);
		return (stored & mask) | (fixed & ~mask);
	endfunction

	// ==========================================================
	// registers
	logic [7:0]      sec_loop_r;
	logic [7:0]      comp_cfg_r;
	logic [7:0]      family_r;
	logic [7:0]      multiple_r;
	logic [7:0]      out_fmt_r;
	logic [7:0]      filter_r;
	logic [2:0]      host_port_control_r;
	logic            strap_taken_r;
	tcb_ahb_req_type req_r;
	logic            wr_pend_r;
	logic [31:0]     hrdata_r;

	// ==========================================================
	// bus slave: zero wait states, always OKAY
	logic            access;
	logic            addr_hit;
	logic [7:0]      acc_index;
	logic [7:0]      rd_byte;
	logic [7:0]      wr_byte;

	assign access      = hsel_i & hready_i & htrans_i[1];
	assign acc_index   = haddr_i[9:2];
	assign addr_hit    = (haddr_i[31:10] == 22'h0) & (haddr_i[1:0] == 2'b00);
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign hrdata_o    = hrdata_r;
	assign wr_byte     = hwdata_i[7:0];

	always_comb begin
		rd_byte = 8'h00;
		if (addr_hit) begin
			unique case (acc_index)
				IDX_SEC_LOOP_CTRL:  rd_byte = rd_mix(sec_loop_r, RST_SEC_LOOP_CTRL,
					WM_SEC_LOOP_CTRL);
				IDX_COMPOSITE_IN:   rd_byte = comp_cfg_r;
				IDX_HOST_IF_STATUS: rd_byte = {5'h00, host_port_strap_i};
				IDX_SYNTH_FAMILY:   rd_byte = rd_mix(family_r, RST_SYNTH_FAMILY,
					WM_SYNTH_FAMILY);
				IDX_SYNTH_MULTIPLE: rd_byte = rd_mix(multiple_r, RST_SYNTH_MULTIPLE,
					WM_SYNTH_MULTIPLE);
				IDX_OUTPUT_FORMAT:  rd_byte = rd_mix(out_fmt_r, RST_OUTPUT_FORMAT,
					WM_OUTPUT_FORMAT);
				IDX_LOOP_FILTER:    rd_byte = rd_mix(filter_r, RST_LOOP_FILTER,
					WM_LOOP_FILTER);
				default:            rd_byte = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_r     <= '0;
			wr_pend_r <= 1'b0;
		end else begin
			wr_pend_r <= access & hwrite_i & addr_hit;
			if (access) begin
				req_r <= '{size: hsize_i, write: hwrite_i, index: acc_index};
			end
		end
	end

	// read data is captured at the address edge so it stands through the data phase
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hrdata_r <= 32'h0000_0000;
		end else if (access && !hwrite_i) begin
			hrdata_r <= {24'h00_0000, rd_byte};
		end
	end

	// ==========================================================
	// straps: caught on the first edge after release, never by the async reset
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			strap_taken_r       <= 1'b0;
			host_port_control_r <= 3'h0;
		end else if (!strap_taken_r) begin
			strap_taken_r       <= 1'b1;
			host_port_control_r <= host_port_strap_i;
		end
	end
	assign host_port_control_o = host_port_control_r;

	// ==========================================================
	// register writes; reserved bits keep their constants through the masks
	logic wr_sec;
	logic wr_comp;
	logic wr_fam;
	logic wr_mult;
	logic wr_fmt;
	logic wr_filt;

	assign wr_sec  = wr_pend_r && req_r.index == IDX_SEC_LOOP_CTRL;
	assign wr_comp = wr_pend_r && req_r.index == IDX_COMPOSITE_IN;
	assign wr_fam  = wr_pend_r && req_r.index == IDX_SYNTH_FAMILY;
	assign wr_mult = wr_pend_r && req_r.index == IDX_SYNTH_MULTIPLE;
	assign wr_fmt  = wr_pend_r && req_r.index == IDX_OUTPUT_FORMAT;
	assign wr_filt = wr_pend_r && req_r.index == IDX_LOOP_FILTER;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sec_loop_r <= RST_SEC_LOOP_CTRL;
			comp_cfg_r <= RST_COMPOSITE_IN;
			multiple_r <= RST_SYNTH_MULTIPLE;
			out_fmt_r  <= RST_OUTPUT_FORMAT;
			filter_r   <= RST_LOOP_FILTER;
		end else begin
			if (wr_sec)  sec_loop_r <= rd_mix(wr_byte, RST_SEC_LOOP_CTRL, WM_SEC_LOOP_CTRL);
			if (wr_comp) comp_cfg_r <= wr_byte;
			if (wr_mult) multiple_r <= rd_mix(wr_byte, RST_SYNTH_MULTIPLE, WM_SYNTH_MULTIPLE);
			if (wr_fmt)  out_fmt_r  <= rd_mix(wr_byte, RST_OUTPUT_FORMAT, WM_OUTPUT_FORMAT);
			if (wr_filt) filter_r   <= rd_mix(wr_byte, RST_LOOP_FILTER, WM_LOOP_FILTER);
		end
	end

	// family bits load from the strap once, then software owns them
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			family_r <= RST_SYNTH_FAMILY;
		end else if (!strap_taken_r) begin
			family_r[B_SYNTH2_FAMILY] <= rate_family_strap_i;
			family_r[B_SYNTH1_FAMILY] <= rate_family_strap_i;
		end else if (wr_fam) begin
			family_r <= rd_mix(wr_byte, RST_SYNTH_FAMILY, WM_SYNTH_FAMILY);
		end
	end

	// ==========================================================
	// secondary loop reference
	logic [3:0] force_code;
	logic       forcing;

	assign force_code = sec_loop_r[3:0];
	assign forcing    = (force_code != 4'h0) && (force_code != 4'hF);

	assign secondary_forced_o      = forcing;
	assign secondary_loop_ref_o    = forcing ? force_code : secondary_auto_ref_i;
	// invalid status still flows from the monitors; only the switch-away is held
	assign secondary_switch_hold_o = forcing && input_invalid_i[force_code];
	assign out8_9_from_primary_o   = sec_loop_r[B_OUT89_SRC];

	// ==========================================================
	// composite inputs
	localparam int IW = $clog2(ERR_INTERVAL + 1);

	logic [IW-1:0] interval_cnt_r;
	logic          interval_end;
	logic [1:0]    irregular_r;
	logic [1:0]    broken_prev_r;
	logic [1:0]    viol_inval_r;
	logic [1:0]    zero_prev_r;
	logic [1:0]    los_inval_r;
	logic [1:0]    bucket_inc_r;
	logic [1:0]    comp_mode;

	assign interval_end = interval_cnt_r == IW'(ERR_INTERVAL - 1);
	assign comp_mode    = ~{comp_cfg_r[B_IN2_FORMAT], comp_cfg_r[B_IN1_FORMAT]};

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			interval_cnt_r <= '0;
		end else begin
			interval_cnt_r <= interval_end ? '0 : interval_cnt_r + 1'b1;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_comp
		logic err_now;

		assign err_now = comp_mode[g] && comp_in_i[g].period_done && comp_in_i[g].period_broken;

		// an error in the last cycle of an interval opens the next one
		always_ff @(posedge clock_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				irregular_r[g]  <= 1'b0;
				bucket_inc_r[g] <= 1'b0;
			end else begin
				bucket_inc_r[g] <= interval_end && irregular_r[g];
				if (interval_end) begin
					irregular_r[g] <= err_now && comp_cfg_r[B_ERR_COUNT_EN];
				end else if (err_now && comp_cfg_r[B_ERR_COUNT_EN]) begin
					irregular_r[g] <= 1'b1;
				end
			end
		end

		// invalid stays until a clean period shows the pattern again
		always_ff @(posedge clock_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				broken_prev_r[g] <= 1'b0;
				viol_inval_r[g]  <= 1'b0;
			end else if (!comp_mode[g] || !comp_cfg_r[B_VIOL_INVAL]) begin
				broken_prev_r[g] <= 1'b0;
				viol_inval_r[g]  <= 1'b0;
			end else if (comp_in_i[g].period_done) begin
				broken_prev_r[g] <= comp_in_i[g].period_broken;
				viol_inval_r[g]  <= comp_in_i[g].period_broken && broken_prev_r[g];
			end
		end

		always_ff @(posedge clock_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				zero_prev_r[g] <= 1'b0;
				los_inval_r[g] <= 1'b0;
			end else if (!comp_mode[g] || !comp_cfg_r[B_LOS_INVAL]) begin
				zero_prev_r[g] <= 1'b0;
				los_inval_r[g] <= 1'b0;
			end else if (comp_in_i[g].bit_strobe) begin
				zero_prev_r[g] <= comp_in_i[g].bit_zero;
				los_inval_r[g] <= comp_in_i[g].bit_zero && zero_prev_r[g];
			end
		end

		always_comb begin
			comp_out_o[g].ref_clk = comp_cfg_r[B_EDGE_SEL] ? comp_in_i[g].bpv_lead
				: comp_in_i[g].next_lead;
			if (!comp_mode[g]) begin
				comp_out_o[g].ref_clk = comp_in_i[g].cmos_clk;
			end
			comp_out_o[g].invalid    = viol_inval_r[g] | los_inval_r[g];
			comp_out_o[g].bucket_inc = bucket_inc_r[g];
		end
	end

	// ==========================================================
	// synthesizers and output formats
	logic [14:0] synth1_khz_r;
	logic [14:0] synth2_khz_r;

	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			synth1_khz_r <= SYNTH_BASE_2048;
			synth2_khz_r <= SYNTH_BASE_2048;
		end else begin
			synth1_khz_r <= synth_khz(family_r[B_SYNTH1_FAMILY],
				multiple_r[B_SYNTH1_MULT +: 2]);
			// the alternate rate overrides whatever family and multiple say
			synth2_khz_r <= family_r[B_SYNTH2_ALT] ? SYNTH_ALT_KHZ
				: synth_khz(family_r[B_SYNTH2_FAMILY], multiple_r[B_SYNTH2_MULT +: 2]);
		end
	end
	assign synth1_khz_o = synth1_khz_r;
	assign synth2_khz_o = synth2_khz_r;

	assign out8_400hz_en_o = out_fmt_r[B_OUT8_400HZ];
	assign out8_8khz_en_o  = !out_fmt_r[B_OUT8_8K_DIS];
	assign out6_en_o       = out_fmt_r[B_OUT6_FMT +: 2] != 2'b00;
	assign out7_en_o       = out_fmt_r[B_OUT7_FMT +: 2] != 2'b00;

	// ==========================================================
	// primary loop controls
	assign use_acq_bandwidth_o   = !primary_secondary_strap_i
		|| (filter_r[B_AUTO_BW] && !primary_locked_i);
	assign integral_freeze_o     = filter_r[B_INT_LIMIT] && freq_at_limit_i;
	assign phase_freq_detector_o = filter_r[B_DET_SEL] && !test_override_i;

endmodule

// *** tb/tcb_config_bank_properties.sv ***
// port-level checks on the timing card configuration bank
module tcb_config_bank_properties
	import tcb_pkg::*;
(
	input	wire logic			clock_i,
	input	wire logic			reset_n_i,
	input	wire logic			hsel_i,
	input	wire logic	[31:0]		haddr_i,
	input	wire logic	[1:0]		htrans_i,
	input	wire logic			hwrite_i,
	input	wire logic			hready_i,
	input	wire logic	[31:0]		hrdata_o,
	input	wire logic			hreadyout_o,
	input	wire logic			hresp_o,
	input	wire logic	[2:0]		host_port_control_o,
	input	wire logic			primary_secondary_strap_i,
	input	wire logic	[3:0]		secondary_auto_ref_i,
	input	wire logic	[14:1]		input_invalid_i,
	input	wire logic	[3:0]		secondary_loop_ref_o,
	input	wire logic			secondary_forced_o,
	input	wire logic			secondary_switch_hold_o,
	input	wire tcb_comp_out_type	[1:0]	comp_out_o,
	input	wire logic			freq_at_limit_i,
	input	wire logic			use_acq_bandwidth_o,
	input	wire logic			integral_freeze_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// sequences
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_hole_read;
		hsel_i && hready_i && htrans_i[1] && !hwrite_i && haddr_i == 32'h0000_0100;
	endsequence
	// a host write to the control register may legally move the forced reference
	sequence s_forced_steady;
		secondary_forced_o && $past(secondary_forced_o) && !$past(hsel_i && hready_i
			&& htrans_i[1] && hwrite_i && haddr_i == {22'h0, IDX_SEC_LOOP_CTRL, 2'h0}, 2)
			##0 $changed(input_invalid_i);
	endsequence
	// ====================
	// assertions
	a_bus_always_okay: assert property (hreadyout_o && !hresp_o)
		else $error("slave stalled or answered with an error");
	a_hole_reads_zero: assert property (s_hole_read |=> hrdata_o == 32'h0)
		else $error("unmapped read returned data");
	a_auto_ref_pass: assert property (!secondary_forced_o |-> secondary_loop_ref_o == secondary_auto_ref_i)
		else $error("automatic reference not passed through");
	a_forced_code_range: assert property (secondary_forced_o |-> secondary_loop_ref_o inside {[4'h1:4'hE]})
		else $error("forced flag with an automatic code");
	a_forced_hold_cause: assert property (secondary_switch_hold_o == (secondary_forced_o && input_invalid_i[secondary_loop_ref_o]))
		else $error("switch hold does not follow forced input validity");
	a_forced_ref_steady: assert property (s_forced_steady |-> $stable(secondary_loop_ref_o))
		else $error("forced reference moved on a validity change");
	a_slave_acq_bw: assert property (!primary_secondary_strap_i |-> use_acq_bandwidth_o)
		else $error("slave mode without acquisition bandwidth");
	a_freeze_needs_limit: assert property (integral_freeze_o |-> freq_at_limit_i)
		else $error("integral frozen away from the limit");
	a_bucket_one_cycle: assert property (comp_out_o[0].bucket_inc |=> !comp_out_o[0].bucket_inc)
		else $error("bucket increment longer than one cycle");
	a_strap_held: assert property (reset_n_i && $past(reset_n_i, 2) |-> $stable(host_port_control_o))
		else $error("host port control changed after reset");
endmodule

bind tcb_config_bank tcb_config_bank_properties i_props (.clock_i, .reset_n_i, .hsel_i, .haddr_i,
	.htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .host_port_control_o,
	.primary_secondary_strap_i, .secondary_auto_ref_i, .input_invalid_i, .secondary_loop_ref_o,
	.secondary_forced_o, .secondary_switch_hold_o, .comp_out_o, .freq_at_limit_i,
	.use_acq_bandwidth_o, .integral_freeze_o);

// *** tb/tcb_host_model.sv ***
// host processor model issuing single-word AHB-Lite transfers
module tcb_host_model (
	input	wire logic		clock_i,
	input	wire logic		hready_i,
	input	wire logic	[31:0]	hrdata_i,
	output	logic			hsel_o,
	output	logic		[31:0]	haddr_o,
	output	logic		[1:0]	htrans_o,
	output	logic			hwrite_o,
	output	logic		[2:0]	hsize_o,
	output	logic		[31:0]	hwdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int	lost = 0;
	initial begin
		hsel_o = 1'h0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'h0;
		hsize_o = 3'h2;
		hwdata_o = 32'h0;
	end
	// ====================
	// transfers
	// a slave that never answers is counted, so the bench cannot hang here
	task automatic wait_ready();
		int k;
		k = 0;
		do begin
			@(posedge clock_i);
			k++;
		end while (hready_i !== 1'h1 && k < 32);
		if (hready_i !== 1'h1) lost++;
	endtask
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] d,
			output logic [31:0] q);
		@(posedge clock_i);
		hsel_o <= 1'h1;
		htrans_o <= 2'h2;
		hwrite_o <= wr;
		hsize_o <= 3'h2;
		haddr_o <= {22'h0, idx, 2'h0};
		wait_ready();
		hsel_o <= 1'h0;
		htrans_o <= 2'h0;
		hwdata_o <= {24'h0, d};
		wait_ready();
		q = hrdata_i;
	endtask
endmodule

// *** tb/tcb_config_bank_bench.sv ***
// self-checking bench for the timing card configuration bank
module tcb_config_bank_bench;
	import tcb_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] RIDX [8] = '{IDX_SEC_LOOP_CTRL, IDX_COMPOSITE_IN, IDX_HOST_IF_STATUS,
		IDX_SYNTH_FAMILY, IDX_SYNTH_MULTIPLE, IDX_OUTPUT_FORMAT, IDX_LOOP_FILTER, 8'h40};
	localparam logic [7:0] RVAL [8] = '{8'h40, 8'h02, 8'h05, 8'h7F, 8'h08, 8'hC6, 8'hFB, 8'h00};
	localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h7, 4'hE, 4'hF};
	// {config, composite input, expected reference}
	localparam logic [15:0] MUX [5] = '{16'h0041, 16'h8040, 16'h8081, 16'h0480, 16'h0403};
	logic	clock_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o;
	logic	[31:0]	haddr_i, hwdata_i, hrdata_o, mx;
	logic	[1:0]	htrans_i;
	logic	[2:0]	hsize_i, host_port_strap_i, host_port_control_o;
	logic	rate_family_strap_i, primary_secondary_strap_i, secondary_forced_o, fe;
	logic	secondary_switch_hold_o, out8_9_from_primary_o, primary_locked_i;
	logic	freq_at_limit_i, test_override_i, use_acq_bandwidth_o, integral_freeze_o;
	logic	phase_freq_detector_o, out8_400hz_en_o, out8_8khz_en_o, out6_en_o, out7_en_o;
	logic	[3:0]	secondary_auto_ref_i, secondary_loop_ref_o, re;
	logic	[14:1]	input_invalid_i;
	logic	[14:0]	synth1_khz_o, synth2_khz_o, kz;
	tcb_comp_in_type	[1:0]	comp_in_i;
	tcb_comp_out_type	[1:0]	comp_out_o;
	int	fails = 0, checks_done = 0, n;

	tcb_config_bank #(.ERR_INTERVAL(64)) i_dut (.clock_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
		.hresp_o, .host_port_strap_i, .rate_family_strap_i, .primary_secondary_strap_i,
		.host_port_control_o, .secondary_auto_ref_i, .input_invalid_i, .secondary_loop_ref_o,
		.secondary_forced_o, .secondary_switch_hold_o, .out8_9_from_primary_o, .comp_in_i,
		.comp_out_o, .synth1_khz_o, .synth2_khz_o, .out8_400hz_en_o, .out8_8khz_en_o,
		.out6_en_o, .out7_en_o, .primary_locked_i, .freq_at_limit_i, .test_override_i,
		.use_acq_bandwidth_o, .integral_freeze_o, .phase_freq_detector_o);
	tcb_host_model i_host (.clock_i, .hready_i(hreadyout_o), .hrdata_i(hrdata_o), .hsel_o(hsel_i),
		.haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i), .hsize_o(hsize_i),
		.hwdata_o(hwdata_i));

	initial begin
		clock_i = 1'h0;
		forever #20 clock_i = ~clock_i;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		fails++;
		end_sim();
	end
	// ====================
	// helpers
	task automatic end_sim();
		fails += i_host.lost;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_reg(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		i_host.xfer(1'h0, idx, 8'h00, q);
		chk_sig(q, {24'h0, exp});
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		i_host.xfer(1'h1, idx, d, q);
	endtask
	// outputs are looked at on the falling edge, clear of the launching edge
	task automatic nx(input int k);
		repeat (k) @(posedge clock_i);
		@(negedge clock_i);
	endtask
	task automatic drive(input logic [6:0] v, input int k);
		@(posedge clock_i);
		comp_in_i[0] <= v;
		repeat (k) @(posedge clock_i);
		comp_in_i[0] <= 7'h00;
		@(negedge clock_i);
	endtask
	// ====================
	// scenarios
	initial begin
		reset_n_i = 1'h0;
		host_port_strap_i = 3'h5;
		rate_family_strap_i = 1'h1;
		primary_secondary_strap_i = 1'h1;
		secondary_auto_ref_i = 4'h9;
		input_invalid_i = '0;
		comp_in_i = '0;
		primary_locked_i = 1'h0;
		freq_at_limit_i = 1'h0;
		test_override_i = 1'h0;
		repeat (8) @(posedge clock_i);
		reset_n_i <= 1'h1;
		for (int i = 0; i < 8; i++) chk_reg(RIDX[i], RVAL[i]);
		nx(0);
		chk_sig({host_port_control_o, synth1_khz_o, synth2_khz_o}, {3'h5, 15'h608, 15'h608});
		chk_sig({out8_400hz_en_o, out8_8khz_en_o, out6_en_o, out7_en_o, use_acq_bandwidth_o,
			integral_freeze_o, phase_freq_detector_o}, 7'h3C);
		@(posedge clock_i);
		host_port_strap_i <= 3'h2;
		wr(IDX_HOST_IF_STATUS, 8'hFF);
		chk_reg(IDX_HOST_IF_STATUS, 8'h02);
		chk_sig(host_port_control_o, 3'h5);
		wr(IDX_SEC_LOOP_CTRL, 8'hFF);
		chk_reg(IDX_SEC_LOOP_CTRL, 8'h5F);
		nx(0);
		chk_sig({out8_9_from_primary_o, secondary_forced_o, secondary_loop_ref_o}, 6'h29);
		for (int i = 0; i < 5; i++) begin
			wr(IDX_SEC_LOOP_CTRL, {4'h0, CODES[i]});
			fe = CODES[i] != 4'h0 && CODES[i] != 4'hF;
			re = fe ? CODES[i] : 4'h9;
			nx(0);
			chk_sig({out8_9_from_primary_o, secondary_forced_o, secondary_loop_ref_o}, {1'h0, fe, re});
		end
		wr(IDX_SEC_LOOP_CTRL, 8'h03);
		@(posedge clock_i);
		input_invalid_i <= 14'h0004;
		secondary_auto_ref_i <= 4'h5;
		nx(1);
		chk_sig({secondary_switch_hold_o, secondary_loop_ref_o}, 5'h13);
		for (int f = 0; f < 2; f++)
			for (int m = 0; m < 4; m++) begin
				wr(IDX_SYNTH_FAMILY, {1'h0, f[0], f[0], 5'h1F});
				wr(IDX_SYNTH_MULTIPLE, {m[1:0], m[1:0], 4'h0});
				kz = (f == 1 ? 15'h608 : 15'h800) << m;
				nx(1);
				chk_sig({synth1_khz_o, synth2_khz_o}, {kz, kz});
			end
		wr(IDX_SYNTH_FAMILY, 8'h80);
		wr(IDX_SYNTH_MULTIPLE, 8'h00);
		nx(1);
		chk_sig({synth1_khz_o, synth2_khz_o}, {15'h800, 15'h18A8});
		wr(IDX_OUTPUT_FORMAT, 8'h30);
		chk_reg(IDX_OUTPUT_FORMAT, 8'hF0);
		nx(0);
		chk_sig({out8_400hz_en_o, out8_8khz_en_o, out6_en_o, out7_en_o}, 4'h8);
		wr(IDX_OUTPUT_FORMAT, 8'h09);
		nx(0);
		chk_sig({out8_400hz_en_o, out8_8khz_en_o, out6_en_o, out7_en_o}, 4'h7);
		@(posedge clock_i);
		primary_locked_i <= 1'h1;
		nx(1);
		chk_sig(use_acq_bandwidth_o, 1'h0);
		wr(IDX_LOOP_FILTER, 8'h00);
		chk_reg(IDX_LOOP_FILTER, 8'h73);
		@(posedge clock_i);
		primary_locked_i <= 1'h0;
		freq_at_limit_i <= 1'h1;
		nx(1);
		chk_sig({use_acq_bandwidth_o, integral_freeze_o, phase_freq_detector_o}, 3'h0);
		@(posedge clock_i);
		primary_secondary_strap_i <= 1'h0;
		nx(1);
		chk_sig(use_acq_bandwidth_o, 1'h1);
		wr(IDX_LOOP_FILTER, 8'h0C);
		nx(0);
		chk_sig({use_acq_bandwidth_o, integral_freeze_o, phase_freq_detector_o}, 3'h7);
		wr(IDX_COMPOSITE_IN, 8'h30);
		drive(7'h06, 2);
		chk_sig(comp_out_o[0].invalid, 1'h1);
		drive(7'h04, 1);
		drive(7'h18, 1);
		chk_sig(comp_out_o[0].invalid, 1'h0);
		drive(7'h10, 1);
		drive(7'h18, 2);
		chk_sig(comp_out_o[0].invalid, 1'h1);
		@(posedge clock_i);
		comp_in_i[1] <= 7'h06;
		nx(1);
		chk_sig(comp_out_o[1].invalid, 1'h0);
		@(posedge clock_i);
		comp_in_i[1] <= 7'h00;
		@(negedge clock_i);
		chk_sig(comp_out_o[1].invalid, 1'h1);
		for (int i = 0; i < 5; i++) begin
			mx = {16'h0, MUX[i]};
			wr(IDX_COMPOSITE_IN, mx[15:8]);
			@(posedge clock_i);
			comp_in_i[0] <= mx[7:1];
			nx(0);
			chk_sig(comp_out_o[0].ref_clk, mx[0]);
		end
		wr(IDX_COMPOSITE_IN, 8'h41);
		chk_reg(IDX_COMPOSITE_IN, 8'h41);
		drive(7'h18, 1);
		n = 0;
		while (comp_out_o[0].bucket_inc !== 1'h1 && n < 200) begin
			@(negedge clock_i);
			n++;
		end
		chk_sig(n < 200, 1'h1);
		end_sim();
	end
endmodule
